/* File: verilog/rpcr_pkg.sv */
// package: register map, field layout and decode tables for the record path bank
package rpcr_pkg;
   localparam logic [7:0] RPCR_ROUTE_OFS = 8'h18;
   localparam logic [7:0] RPCR_BIAS_OFS = 8'h19;
   localparam logic [7:0] RPCR_AGC_OFS = 8'h1A;

   localparam int RPCR_DIFF_BIT = 7;
   localparam int RPCR_LVL_LSB = 3;
   localparam int RPCR_BIAS_LSB = 6;
   localparam int RPCR_AGC_EN_BIT = 7;
   localparam int RPCR_TGT_LSB = 4;
   localparam int RPCR_ATK_LSB = 2;
   localparam int RPCR_DCY_LSB = 0;

   localparam logic [7:0] RPCR_ROUTE_RST = 8'h78;
   localparam logic [7:0] RPCR_BIAS_RST = 8'h00;
   localparam logic [7:0] RPCR_AGC_RST = 8'h00;
   localparam logic [7:0] RPCR_ROUTE_WMASK = 8'hF8;
   localparam logic [7:0] RPCR_BIAS_WMASK = 8'hFF;

   localparam logic [3:0] RPCR_LVL_MAX = 4'h8;
   localparam logic [3:0] RPCR_LVL_OFF = 4'hF;
   // attenuation in tenths of a dB per level step
   localparam logic [7:0] RPCR_LVL_STEP_DDB = 8'h0F;

   // gain-control time constants in milliseconds
   localparam int RPCR_ATK_MS0 = 8;
   localparam int RPCR_ATK_MS1 = 11;
   localparam int RPCR_ATK_MS2 = 16;
   localparam int RPCR_ATK_MS3 = 20;
   localparam int RPCR_DCY_MS0 = 100;
   localparam int RPCR_DCY_MS1 = 200;
   localparam int RPCR_DCY_MS2 = 400;
   localparam int RPCR_DCY_MS3 = 500;
   // target levels in tenths of a dB below full scale
   localparam logic [7:0] RPCR_TGT0 = 8'h37;
   localparam logic [7:0] RPCR_TGT1 = 8'h50;
   localparam logic [7:0] RPCR_TGT2 = 8'h64;
   localparam logic [7:0] RPCR_TGT3 = 8'h78;
   localparam logic [7:0] RPCR_TGT4 = 8'h8C;
   localparam logic [7:0] RPCR_TGT5 = 8'hAA;
   localparam logic [7:0] RPCR_TGT6 = 8'hC8;
   localparam logic [7:0] RPCR_TGT7 = 8'hF0;

   typedef enum {
      RPCR_BIAS_OFF,
      RPCR_BIAS_2V0,
      RPCR_BIAS_2V5,
      RPCR_BIAS_RAIL
   } rpcr_bias_t;
endpackage

/* File: verilog/rpcr_agc_decode.sv */
// gain-control field decode: target level and time constants
`timescale 1ns/1ps
module rpcr_agc_decode
   import rpcr_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] agc_reg,
   output logic agc_run,
   output logic [7:0] agc_target_ddb,
   output logic [9:0] agc_attack_ms,
   output logic [9:0] agc_decay_ms
);
   function automatic logic [9:0] pick_ms(input logic [1:0] code,
                                          input int t0, input int t1,
                                          input int t2, input int t3);
      int t;
      case (code)
         2'h0: t = t0;
         2'h1: t = t1;
         2'h2: t = t2;
         default: t = t3;
      endcase
      return t[9:0];
   endfunction

   function automatic logic [7:0] target_of(input logic [2:0] code);
      case (code)
         3'h0: return RPCR_TGT0;
         3'h1: return RPCR_TGT1;
         3'h2: return RPCR_TGT2;
         3'h3: return RPCR_TGT3;
         3'h4: return RPCR_TGT4;
         3'h5: return RPCR_TGT5;
         3'h6: return RPCR_TGT6;
         default: return RPCR_TGT7;
      endcase
   endfunction

   // times hold at single rate only; double-rate scaling is left to the core
   always_ff @(posedge clock) begin
      if (reset) begin
         agc_run <= 1'b0;
         agc_target_ddb <= RPCR_TGT0;
         agc_attack_ms <= pick_ms(2'h0, RPCR_ATK_MS0, RPCR_ATK_MS1,
                                  RPCR_ATK_MS2, RPCR_ATK_MS3);
         agc_decay_ms <= pick_ms(2'h0, RPCR_DCY_MS0, RPCR_DCY_MS1,
                                 RPCR_DCY_MS2, RPCR_DCY_MS3);
      end else begin
         agc_run <= agc_reg[RPCR_AGC_EN_BIT];
         agc_target_ddb <= target_of(agc_reg[RPCR_TGT_LSB +: 3]);
         agc_attack_ms <= pick_ms(agc_reg[RPCR_ATK_LSB +: 2], RPCR_ATK_MS0,
            RPCR_ATK_MS1, RPCR_ATK_MS2, RPCR_ATK_MS3);
         agc_decay_ms <= pick_ms(agc_reg[RPCR_DCY_LSB +: 2], RPCR_DCY_MS0,
            RPCR_DCY_MS1, RPCR_DCY_MS2, RPCR_DCY_MS3);
      end
   end

   AST_AGC_RUN: assert property (@(posedge clock) disable iff (reset)
      agc_reg[RPCR_AGC_EN_BIT] |=> agc_run)
      else $error("gain control not running while enabled");
   AST_AGC_STOP: assert property (@(posedge clock) disable iff (reset)
      !agc_reg[RPCR_AGC_EN_BIT] |=> !agc_run)
      else $error("gain control running while disabled");
   AST_TGT_END: assert property (@(posedge clock) disable iff (reset)
      agc_reg[6:4] == 3'h7 |=> agc_target_ddb == 8'hF0)
      else $error("deepest target level wrong");
   AST_ATK_FIRST: assert property (@(posedge clock) disable iff (reset)
      agc_reg[3:2] == 2'h0 |=> agc_attack_ms == 10'h008)
      else $error("shortest attack time wrong");
   AST_DCY_LAST: assert property (@(posedge clock) disable iff (reset)
      agc_reg[1:0] == 2'h3 |=> agc_decay_ms == 10'h1F4)
      else $error("longest decay time wrong");
endmodule

/* File: verilog/rpcr_regs.sv */
// record path configuration register bank with field decode
`timescale 1ns/1ps
module rpcr_regs
   import rpcr_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   output logic line_diff_mode,
   output logic line_connect,
   output logic [7:0] line_atten_ddb,
   output rpcr_bias_t mic_bias_mode,
   output logic agc_run,
   output logic [7:0] agc_target_ddb,
   output logic [9:0] agc_attack_ms,
   output logic [9:0] agc_decay_ms
);
   logic [7:0] route_r;
   logic [7:0] bias_r;
   logic [7:0] agc_r;
   logic [3:0] level;

   assign level = route_r[RPCR_LVL_LSB +: 4];

   // write and read decode; the write decode is shared by the registers and their checks
   function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                   input logic [7:0] ofs);
      return wr && addr == ofs;
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      return addr == RPCR_ROUTE_OFS || addr == RPCR_BIAS_OFS ||
         addr == RPCR_AGC_OFS;
   endfunction

   always_ff @(posedge clock) begin
      if (reset) begin
         route_r <= RPCR_ROUTE_RST;
      end else if (wr_hit(reg_write, reg_addr, RPCR_ROUTE_OFS)) begin
         route_r <= reg_wdata & RPCR_ROUTE_WMASK;
      end
   end

   // low bias bits are stored as written; the host keeps them zero
   always_ff @(posedge clock) begin
      if (reset) begin
         bias_r <= RPCR_BIAS_RST;
      end else if (wr_hit(reg_write, reg_addr, RPCR_BIAS_OFS)) begin
         bias_r <= reg_wdata & RPCR_BIAS_WMASK;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         agc_r <= RPCR_AGC_RST;
      end else if (wr_hit(reg_write, reg_addr, RPCR_AGC_OFS)) begin
         agc_r <= reg_wdata;
      end
   end

   // read data and hit are registered: they follow reg_addr one clock late,
   // so a read sets the offset and takes the data on the next cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else begin
         reg_hit <= is_mapped(reg_addr);
         case (reg_addr)
            RPCR_ROUTE_OFS: reg_rdata <= route_r;
            RPCR_BIAS_OFS: reg_rdata <= bias_r;
            RPCR_AGC_OFS: reg_rdata <= agc_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   function automatic logic [7:0] atten_of(input logic [3:0] code);
      logic [7:0] prod;
      prod = 8'h00;
      // reserved codes are never written, so they clamp to the deepest step
      if (code <= RPCR_LVL_MAX) begin
         prod = 8'(code * RPCR_LVL_STEP_DDB);
      end else begin
         prod = 8'(RPCR_LVL_MAX * RPCR_LVL_STEP_DDB);
      end
      return prod;
   endfunction

   always_ff @(posedge clock) begin
      if (reset) begin
         line_diff_mode <= 1'b0;
         line_connect <= 1'b0;
         line_atten_ddb <= 8'h00;
      end else begin
         line_diff_mode <= route_r[RPCR_DIFF_BIT];
         line_connect <= level != RPCR_LVL_OFF;
         line_atten_ddb <= atten_of(level);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         mic_bias_mode <= RPCR_BIAS_OFF;
      end else begin
         case (bias_r[RPCR_BIAS_LSB +: 2])
            2'h0: mic_bias_mode <= RPCR_BIAS_OFF;
            2'h1: mic_bias_mode <= RPCR_BIAS_2V0;
            2'h2: mic_bias_mode <= RPCR_BIAS_2V5;
            default: mic_bias_mode <= RPCR_BIAS_RAIL;
         endcase
      end
   end

   rpcr_agc_decode u_agc (
      .clock(clock),
      .reset(reset),
      .agc_reg(agc_r),
      .agc_run(agc_run),
      .agc_target_ddb(agc_target_ddb),
      .agc_attack_ms(agc_attack_ms),
      .agc_decay_ms(agc_decay_ms)
   );

   // a write, then the clock in which the register already holds it
   sequence route_written;
      wr_hit(reg_write, reg_addr, RPCR_ROUTE_OFS) ##1 1'b1;
   endsequence

   sequence bias_written;
      wr_hit(reg_write, reg_addr, RPCR_BIAS_OFS) ##1 1'b1;
   endsequence

   AST_RESET_LOAD: assert property (@(posedge clock)
      $fell(reset) |-> route_r == 8'h78 && bias_r == 8'h00 && agc_r == 8'h00)
      else $error("reset defaults not loaded");

   AST_RESET_OUT: assert property (@(posedge clock)
      reset |=> !line_connect && !line_diff_mode && line_atten_ddb == 8'h00
         && mic_bias_mode == RPCR_BIAS_OFF)
      else $error("decoded outputs not at defaults after reset");

   AST_ROUTE_STORE: assert property (@(posedge clock)
      disable iff (reset) wr_hit(reg_write, reg_addr, RPCR_ROUTE_OFS)
      |=> route_r == {$past(reg_wdata[7:3]), 3'h0})
      else $error("route register not stored with low bits clear");

   AST_LOW_ZERO: assert property (@(posedge clock) disable iff (reset)
      reg_addr == RPCR_ROUTE_OFS |=> reg_hit && reg_rdata[2:0] == 3'h0)
      else $error("route low bits not zero");

   AST_READ_ROUTE: assert property (@(posedge clock)
      disable iff (reset)
      reg_addr == RPCR_ROUTE_OFS |=> reg_rdata == $past(route_r))
      else $error("route register read back wrong");

   AST_DIFF_FOLLOW: assert property (@(posedge clock)
      disable iff (reset)
      route_written |=> line_diff_mode == $past(reg_wdata[RPCR_DIFF_BIT], 2))
      else $error("input mode not following write");

   AST_LEVEL_FOLLOW: assert property (@(posedge clock)
      disable iff (reset)
      route_written |=> line_connect == ($past(reg_wdata[6:3], 2) != 4'hF))
      else $error("connection not following written level");

   AST_DISCONNECT: assert property (@(posedge clock) disable iff (reset)
      level == 4'hF |=> !line_connect)
      else $error("input connected with level 1111");

   AST_CONNECT: assert property (@(posedge clock) disable iff (reset)
      level <= 4'h8 |=> line_connect
         && line_atten_ddb == 8'($past(level) * 8'h0F))
      else $error("gain code not connected with right step");

   AST_ATTEN_DEEPEST: assert property (@(posedge clock)
      disable iff (reset)
      level == RPCR_LVL_MAX |=> line_atten_ddb == 8'h78)
      else $error("deepest level step not twelve dB");

   AST_ATTEN_ZERO: assert property (@(posedge clock)
      disable iff (reset)
      level == 4'h0 |=> line_atten_ddb == 8'h00)
      else $error("first level step not zero dB");

   AST_BIAS_FOLLOW: assert property (@(posedge clock)
      disable iff (reset)
      bias_written
      |=> mic_bias_mode == rpcr_bias_t'($past(reg_wdata[7:6], 2)))
      else $error("bias level not following write");

   AST_BIAS_RAIL: assert property (@(posedge clock) disable iff (reset)
      bias_r[7:6] == 2'h3 |=> mic_bias_mode == RPCR_BIAS_RAIL)
      else $error("bias not tied to rail");

   AST_BIAS_OFF: assert property (@(posedge clock) disable iff (reset)
      bias_r[7:6] == 2'h0 |=> mic_bias_mode == RPCR_BIAS_OFF)
      else $error("bias output not powered down");

   AST_BIAS_STORE: assert property (@(posedge clock)
      disable iff (reset) wr_hit(reg_write, reg_addr, RPCR_BIAS_OFS)
      |=> bias_r == $past(reg_wdata))
      else $error("bias register not stored");

   AST_AGC_STORE: assert property (@(posedge clock)
      disable iff (reset) wr_hit(reg_write, reg_addr, RPCR_AGC_OFS)
      |=> agc_r == $past(reg_wdata))
      else $error("gain-control register not stored");
endmodule

/* File: sim/rpcr_regs_test.sv */
// self-checking bench for the record path register bank
`timescale 1ns/1ps
`define CHK(got, exp) check(32'(got), 32'(exp))
module rpcr_regs_test import rpcr_pkg::*;;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic reg_write = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_hit;
   logic line_diff_mode;
   logic line_connect;
   logic [7:0] line_atten_ddb;
   rpcr_bias_t mic_bias_mode;
   logic agc_run;
   logic [7:0] agc_target_ddb;
   logic [9:0] agc_attack_ms;
   logic [9:0] agc_decay_ms;
   int mismatches = 0;
   int comparisons = 0;
   // target levels in tenths of a dB, attack and decay in ms
   logic [7:0] tgt [8] = '{8'h37, 8'h50, 8'h64, 8'h78, 8'h8C, 8'hAA, 8'hC8,
      8'hF0};
   int atk [4] = '{8, 11, 16, 20};
   int dcy [4] = '{100, 200, 400, 500};

   rpcr_regs i_dut (.clock(clock), .reset(reset), .reg_write(reg_write),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .line_diff_mode(line_diff_mode),
      .line_connect(line_connect), .line_atten_ddb(line_atten_ddb),
      .mic_bias_mode(mic_bias_mode), .agc_run(agc_run),
      .agc_target_ddb(agc_target_ddb), .agc_attack_ms(agc_attack_ms),
      .agc_decay_ms(agc_decay_ms));

   always #12.5 clock = ~clock;

   task check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // returns once the decoded outputs have taken the new value
   task write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      reg_write = 1'b1;
      reg_addr = addr;
      reg_wdata = data;
      @(negedge clock);
      reg_write = 1'b0;
      @(negedge clock);
   endtask

   task read_chk(input logic [7:0] addr, input logic [7:0] exp,
      input logic hit);
      @(negedge clock);
      reg_addr = addr;
      @(negedge clock);
      `CHK(reg_rdata, exp);
      `CHK(reg_hit, hit);
   endtask

   task reset_defaults;
      read_chk(RPCR_ROUTE_OFS, 8'h78, 1'b1);
      read_chk(RPCR_BIAS_OFS, 8'h00, 1'b1);
      read_chk(RPCR_AGC_OFS, 8'h00, 1'b1);
      `CHK({line_diff_mode, line_connect, agc_run}, 3'h0);
      `CHK(mic_bias_mode, RPCR_BIAS_OFF);
      `CHK({agc_target_ddb, agc_attack_ms, agc_decay_ms},
         {8'h37, 10'h008, 10'h064});
   endtask

   task route_levels;
      write_reg(RPCR_ROUTE_OFS, 8'hFF);
      read_chk(RPCR_ROUTE_OFS, 8'hF8, 1'b1);
      `CHK(line_diff_mode, 1'h1);
      `CHK(line_connect, 1'h0);
      for (int l = 0; l <= 8; l++) begin
         write_reg(RPCR_ROUTE_OFS, 8'(l << 3));
         `CHK(line_diff_mode, 1'h0);
         `CHK(line_connect, 1'h1);
         `CHK(line_atten_ddb, 8'(l * 8'h0F));
      end
   endtask

   task bias_modes;
      for (int c = 0; c < 4; c++) begin
         write_reg(RPCR_BIAS_OFS, 8'(c << 6));
         `CHK(mic_bias_mode, rpcr_bias_t'(c));
      end
   endtask

   task agc_fields;
      for (int t = 0; t < 8; t++) begin
         write_reg(RPCR_AGC_OFS, {1'b1, 3'(t), 2'(t), 2'(3 - t % 4)});
         `CHK(agc_run, 1);
         `CHK(agc_target_ddb, tgt[t]);
         `CHK(agc_attack_ms, atk[t % 4]);
         `CHK(agc_decay_ms, dcy[3 - t % 4]);
      end
      write_reg(RPCR_AGC_OFS, 8'h7F);
      `CHK(agc_run, 0);
   endtask

   // back-to-back writes, two of them to places outside the map
   task burst_unmapped;
      @(negedge clock);
      reg_write = 1'b1;
      reg_addr = RPCR_AGC_OFS;
      reg_wdata = 8'hA5;
      @(negedge clock);
      reg_addr = 8'h1B;
      reg_wdata = 8'hFF;
      @(negedge clock);
      reg_addr = 8'h17;
      @(negedge clock);
      reg_addr = RPCR_BIAS_OFS;
      reg_wdata = 8'h40;
      @(negedge clock);
      reg_write = 1'b0;
      read_chk(8'h1B, 8'h00, 1'b0);
      read_chk(8'h17, 8'h00, 1'b0);
      read_chk(RPCR_AGC_OFS, 8'hA5, 1'b1);
      read_chk(RPCR_BIAS_OFS, 8'h40, 1'b1);
      `CHK({agc_run, agc_target_ddb, agc_attack_ms, agc_decay_ms},
         {1'b1, 8'h64, 10'h00B, 10'h0C8});
      `CHK(mic_bias_mode, RPCR_BIAS_2V0);
   endtask

   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (3) @(negedge clock);
      reset = 1'b0;
      reset_defaults();
      route_levels();
      bias_modes();
      agc_fields();
      burst_unmapped();
      // a second reset in mid-run must restore every default
      @(negedge clock);
      reset = 1'b1;
      repeat (3) @(negedge clock);
      reset = 1'b0;
      reset_defaults();
      print_verdict();
   end
endmodule
